// [fpq_defines.svh]
// constants for the flash protect and query controller
`ifndef FPQ_DEFINES_SVH
`define FPQ_DEFINES_SVH
`define FPQ_NUM_SECT 142
`define FPQ_BOOT_LO_LAST 8'd3
`define FPQ_BOOT_HI_FIRST 8'd138
`define FPQ_BOOT_HI_LAST 8'd141
`define FPQ_UNLOCK1_ADDR 12'h555
`define FPQ_UNLOCK2_ADDR 12'h2aa
`define FPQ_UNLOCK1_DATA 8'haa
`define FPQ_UNLOCK2_DATA 8'h55
`define FPQ_QUERY_ADDR 12'h055
`define FPQ_CMD_QUERY 8'h98
`define FPQ_CMD_RESET 8'hf0
`define FPQ_CMD_AUTOSEL 8'h90
`define FPQ_CMD_PROGRAM 8'ha0
`define FPQ_CMD_ERASE 8'h80
`define FPQ_CMD_SECT_ERASE 8'h30
`define FPQ_CMD_REGION_ENTER 8'h88
`define FPQ_CMD_REGION_EXIT 8'h90
`define FPQ_CMD_ERASE_SUSP 8'hb0
`define FPQ_CMD_ERASE_RES 8'h30
`define FPQ_CMD_REGION_LOCK 8'h60
`define FPQ_CMD_PLOCK_SET 8'hc0
`define FPQ_CMD_DLOCK_SET 8'he0
`define FPQ_CMD_DLOCK_CLR 8'he1
`define FPQ_CMD_PLOCK_CLR 8'hc1
`endif

// [fpq_pkg.sv]
// types for the flash protect and query controller
package fpq_pkg;
    typedef enum logic [3:0] {
        FPQ_IDLE = 4'h0,
        FPQ_UNL1 = 4'h1,
        FPQ_UNL2 = 4'h2,
        FPQ_PROG = 4'h3,
        FPQ_ER_UNL0 = 4'h4,
        FPQ_ER_UNL1 = 4'h5,
        FPQ_ER_UNL2 = 4'h6
    } fpq_seq_t;
    typedef enum logic [2:0] {
        FPQ_M_READ = 3'h0,
        FPQ_M_AUTOSEL = 3'h1,
        FPQ_M_QUERY = 3'h2,
        FPQ_M_QUERY_AS = 3'h3,
        FPQ_M_REGION = 3'h4
    } fpq_mode_t;
endpackage

// [fpq_ctrl.sv]
// write protection, command decode and query table of the flash controller
//
// Operation
// - locked secured region can never be unlocked nor any of its bits changed.
// - region entry sequence then protect command locks the secured region.
// - program aimed at locked secured region is rejected, contents unchanged.
// - program and erase start only after both unlock cycles.
// - persistent and dynamic lock bit commands disable or enable sector writes.
// - write-protect low blocks the eight outermost boot sectors.
// - write-protect high leaves boot sectors to their lock bits.
// - boost supply pin low locks every sector.
// - supply lockout drops writes, aborts sequences, returns to array read.
// - write starts only with select and strobe low, output enable high.
// - no command accepted during power-up; start in read mode.
// - write 98h at 55h from array read enters query mode.
// - query also from identification; reset returns to origin mode.
// - query words 10h-12h give 0051h 0052h 0059h and pointers.
// - extended table at 40h: 0050h 0052h 0049h, version 0031h 0033h.
// - word 49h reports 0007h advanced sector protection.
// - word 4Fh reports 0001h dual boot.
// - words 58h-5Bh give bank sector counts 0017h and 0030h.
// - bad sequence is recovered by the reset command.
// - erase suspend puts the bank into erase-suspend-read.
// - reset clears timeout or identification back to read or suspend-read.
// - array read after power-up and after program or erase completes.
// - reset command accepted whatever the address bits.
`timescale 1ns/10ps
`include "fpq_defines.svh"
module fpq_ctrl
    import fpq_pkg::*;
(
    input wire logic CLK, // clock
    input wire logic RST, // async reset, high
    input wire logic CE_N, // chip select, low
    input wire logic WE_N, // write strobe, low
    input wire logic OE_N, // output enable, low
    input wire logic [11:0] ADDR, // word address low bits
    input wire logic [7:0] SECT, // sector number of address
    input wire logic REGION_ADDR, // address falls in secured region
    input wire logic [15:0] DIN, // write data
    input wire logic WP_N, // write-protect pin, low
    input wire logic BOOST_SUPPLY_PIN, // boost supply pin, low locks all
    input wire logic SUPPLY_LOCKOUT, // supply below lockout level
    input wire logic POWER_UP, // power-up phase active
    input wire logic ALGO_DONE, // embedded program or erase finished
    input wire logic TIMEOUT_STATUS_BIT, // embedded timeout seen
    output logic [15:0] QUERY_DATA, // query table word
    output logic QUERY_MODE, // query reads active
    output logic AUTOSEL_MODE, // identification mode
    output logic REGION_MODE, // secured region mapped
    output logic REGION_LOCKED, // secured region permanently locked
    output logic PROG_START, // program accepted, one cycle
    output logic ERASE_START, // sector erase accepted, one cycle
    output logic [7:0] OP_SECT, // sector of accepted operation
    output logic BUSY, // embedded operation running
    output logic ERASE_SUSPENDED, // bank in erase-suspend-read
    output logic SECT_WRITABLE // addressed sector writable now
);
    fpq_seq_t seq_q;
    fpq_mode_t mode_q;
    fpq_mode_t query_ret_q;
    logic [`FPQ_NUM_SECT-1:0] plock_q;
    logic [`FPQ_NUM_SECT-1:0] dlock_q;
    logic region_lock_q;
    logic busy_q;
    logic susp_q;
    logic erasing_q;
    logic lock_arm_q;
    logic wr_prev_q;
    logic wr_act;
    logic wr_ev;
    logic boot_sect;
    logic sect_prot;
    logic [7:0] cmd;
    logic is_reset;
    logic in_sect;

    assign in_sect = (SECT < 8'(`FPQ_NUM_SECT));
    assign cmd = DIN[7:0];
    assign wr_act = !CE_N && !WE_N && OE_N;
    // command taken once per write cycle, blocked by lockout and power-up
    assign wr_ev = wr_act && !wr_prev_q && !SUPPLY_LOCKOUT && !POWER_UP;
    assign is_reset = wr_ev && (cmd == `FPQ_CMD_RESET);
    assign boot_sect = (SECT <= `FPQ_BOOT_LO_LAST) || (SECT >= `FPQ_BOOT_HI_FIRST && SECT <= `FPQ_BOOT_HI_LAST);

    always_comb begin
        sect_prot = 1'b1;
        if (in_sect) begin
            sect_prot = plock_q[SECT] || dlock_q[SECT];
        end
        if (!WP_N && boot_sect) begin
            sect_prot = 1'b1;
        end
        if (!BOOST_SUPPLY_PIN) begin
            sect_prot = 1'b1;
        end
    end

    always_comb begin
        SECT_WRITABLE = !sect_prot;
        if (mode_q == FPQ_M_REGION) begin
            SECT_WRITABLE = !region_lock_q;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wr_prev_q <= 1'b0;
        end else begin
            wr_prev_q <= wr_act;
        end
    end

    // unlock sequence tracker
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            seq_q <= FPQ_IDLE;
        end else if (SUPPLY_LOCKOUT || is_reset) begin
            seq_q <= FPQ_IDLE;
        end else if (wr_ev && !busy_q) begin
            unique case (seq_q)
                FPQ_IDLE: begin
                    seq_q <= (ADDR == `FPQ_UNLOCK1_ADDR && cmd == `FPQ_UNLOCK1_DATA) ? FPQ_UNL1 : FPQ_IDLE;
                end
                FPQ_UNL1: begin
                    seq_q <= (ADDR == `FPQ_UNLOCK2_ADDR && cmd == `FPQ_UNLOCK2_DATA) ? FPQ_UNL2 : FPQ_IDLE;
                end
                FPQ_UNL2: begin
                    // lock code 60h arms the region lock instead of a program
                    if (cmd == `FPQ_CMD_PROGRAM || cmd == `FPQ_CMD_REGION_LOCK) begin
                        seq_q <= FPQ_PROG;
                    end else if (cmd == `FPQ_CMD_ERASE && !susp_q) begin
                        seq_q <= FPQ_ER_UNL0;
                    end else begin
                        seq_q <= FPQ_IDLE;
                    end
                end
                FPQ_PROG: begin
                    seq_q <= FPQ_IDLE;
                end
                FPQ_ER_UNL0: begin
                    seq_q <= (ADDR == `FPQ_UNLOCK1_ADDR && cmd == `FPQ_UNLOCK1_DATA) ? FPQ_ER_UNL1 : FPQ_IDLE;
                end
                FPQ_ER_UNL1: begin
                    seq_q <= (ADDR == `FPQ_UNLOCK2_ADDR && cmd == `FPQ_UNLOCK2_DATA) ? FPQ_ER_UNL2 : FPQ_IDLE;
                end
                FPQ_ER_UNL2: begin
                    seq_q <= FPQ_IDLE;
                end
                default: begin
                    seq_q <= FPQ_IDLE;
                end
            endcase
        end
    end

    logic lock_cmd;
    logic prog_go;
    logic erase_go;
    logic query_go;
    logic resume_go;
    assign lock_cmd = wr_ev && !busy_q && seq_q == FPQ_UNL2;
    assign prog_go = wr_ev && !busy_q && seq_q == FPQ_PROG && mode_q != FPQ_M_REGION && !sect_prot
        && !lock_arm_q;
    // query entry allowed from array read and identification
    assign query_go = wr_ev && !busy_q && ADDR == `FPQ_QUERY_ADDR && cmd == `FPQ_CMD_QUERY
        && (mode_q == FPQ_M_READ || mode_q == FPQ_M_AUTOSEL);
    assign resume_go = wr_ev && !busy_q && susp_q && seq_q == FPQ_IDLE && cmd == `FPQ_CMD_ERASE_RES;
    assign erase_go = wr_ev && !busy_q && seq_q == FPQ_ER_UNL2 && cmd == `FPQ_CMD_SECT_ERASE
        && mode_q == FPQ_M_READ && !sect_prot;

    // region lock bit: set only, never cleared except by power loss model
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            region_lock_q <= 1'b0;
        end else if (wr_ev && !busy_q && seq_q == FPQ_PROG && mode_q == FPQ_M_REGION && !region_lock_q
            && cmd == `FPQ_CMD_REGION_LOCK && lock_arm_q) begin
            region_lock_q <= 1'b1;
        end
    end

    // lock code after two unlocks: next write of 60h in region mode locks region, never programs
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            lock_arm_q <= 1'b0;
        end else if (SUPPLY_LOCKOUT || is_reset) begin
            lock_arm_q <= 1'b0;
        end else if (wr_ev && !busy_q) begin
            lock_arm_q <= (seq_q == FPQ_UNL2) && (cmd == `FPQ_CMD_REGION_LOCK);
        end
    end

    // per-sector lock bits
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            plock_q <= '0;
            dlock_q <= '0;
        end else if (lock_cmd && in_sect && mode_q == FPQ_M_READ) begin
            unique case (cmd)
                `FPQ_CMD_PLOCK_SET: plock_q[SECT] <= 1'b1;
                `FPQ_CMD_PLOCK_CLR: plock_q <= '0;
                `FPQ_CMD_DLOCK_SET: dlock_q[SECT] <= 1'b1;
                `FPQ_CMD_DLOCK_CLR: dlock_q[SECT] <= 1'b0;
                default: begin
                end
            endcase
        end
    end

    // embedded operation and suspend
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            busy_q <= 1'b0;
            susp_q <= 1'b0;
        end else if (SUPPLY_LOCKOUT) begin
            busy_q <= 1'b0;
            susp_q <= 1'b0;
        end else if (busy_q) begin
            if (ALGO_DONE || (TIMEOUT_STATUS_BIT && is_reset)) begin
                busy_q <= 1'b0;
            end else if (wr_ev && cmd == `FPQ_CMD_ERASE_SUSP && !susp_q && erasing_q) begin
                busy_q <= 1'b0;
                susp_q <= 1'b1;
            end
        end else if (prog_go || erase_go) begin
            busy_q <= 1'b1;
        end else if (resume_go) begin
            busy_q <= 1'b1;
            susp_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PROG_START <= 1'b0;
            ERASE_START <= 1'b0;
            OP_SECT <= 8'h00;
        end else begin
            PROG_START <= prog_go;
            ERASE_START <= erase_go;
            if (prog_go || erase_go) begin
                OP_SECT <= SECT;
            end
        end
    end

    // kind of running operation: only an erase may be suspended
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            erasing_q <= 1'b0;
        end else if (SUPPLY_LOCKOUT) begin
            erasing_q <= 1'b0;
        end else if (erase_go || resume_go) begin
            erasing_q <= 1'b1;
        end else if (prog_go) begin
            erasing_q <= 1'b0;
        end else if (busy_q && ALGO_DONE) begin
            erasing_q <= 1'b0;
        end
    end

    // read mode tracking
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mode_q <= FPQ_M_READ;
        end else if (SUPPLY_LOCKOUT) begin
            mode_q <= FPQ_M_READ;
        end else if (is_reset && !busy_q) begin
            unique case (mode_q)
                FPQ_M_QUERY: mode_q <= query_ret_q;
                FPQ_M_QUERY_AS: mode_q <= query_ret_q;
                FPQ_M_REGION: mode_q <= FPQ_M_REGION;
                default: mode_q <= FPQ_M_READ;
            endcase
        end else if (query_go) begin
            mode_q <= (mode_q == FPQ_M_AUTOSEL) ? FPQ_M_QUERY_AS : FPQ_M_QUERY;
        end else if (wr_ev && !busy_q && seq_q == FPQ_UNL2) begin
            if (cmd == `FPQ_CMD_AUTOSEL && mode_q == FPQ_M_READ) begin
                mode_q <= FPQ_M_AUTOSEL;
            end else if (cmd == `FPQ_CMD_REGION_ENTER && mode_q == FPQ_M_READ && !susp_q) begin
                mode_q <= FPQ_M_REGION;
            end
        end else if (wr_ev && seq_q == FPQ_ER_UNL2 && mode_q == FPQ_M_REGION && cmd == 8'h00) begin
            mode_q <= FPQ_M_READ;
        end
    end

    // mode to go back to when query mode is left
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            query_ret_q <= FPQ_M_READ;
        end else if (SUPPLY_LOCKOUT) begin
            query_ret_q <= FPQ_M_READ;
        end else if (query_go) begin
            query_ret_q <= mode_q;
        end
    end

    // query table, byte on low lane
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            QUERY_DATA <= 16'h0000;
        end else begin
            unique case (ADDR[7:0])
                8'h10: QUERY_DATA <= 16'h0051;
                8'h11: QUERY_DATA <= 16'h0052;
                8'h12: QUERY_DATA <= 16'h0059;
                8'h13: QUERY_DATA <= 16'h0002;
                8'h15: QUERY_DATA <= 16'h0040;
                8'h40: QUERY_DATA <= 16'h0050;
                8'h41: QUERY_DATA <= 16'h0052;
                8'h42: QUERY_DATA <= 16'h0049;
                8'h43: QUERY_DATA <= 16'h0031;
                8'h44: QUERY_DATA <= 16'h0033;
                8'h45: QUERY_DATA <= 16'h000c;
                8'h46: QUERY_DATA <= 16'h0002;
                8'h47: QUERY_DATA <= 16'h0001;
                8'h49: QUERY_DATA <= 16'h0007;
                8'h4a: QUERY_DATA <= 16'h0077;
                8'h4b: QUERY_DATA <= 16'h0001;
                8'h4d: QUERY_DATA <= 16'h00b5;
                8'h4e: QUERY_DATA <= 16'h00c5;
                8'h4f: QUERY_DATA <= 16'h0001;
                8'h57: QUERY_DATA <= 16'h0004;
                8'h58: QUERY_DATA <= 16'h0017;
                8'h59: QUERY_DATA <= 16'h0030;
                8'h5a: QUERY_DATA <= 16'h0030;
                8'h5b: QUERY_DATA <= 16'h0017;
                default: QUERY_DATA <= 16'h0000;
            endcase
        end
    end

    assign QUERY_MODE = (mode_q == FPQ_M_QUERY) || (mode_q == FPQ_M_QUERY_AS);
    assign AUTOSEL_MODE = (mode_q == FPQ_M_AUTOSEL);
    assign REGION_MODE = (mode_q == FPQ_M_REGION);
    assign REGION_LOCKED = region_lock_q;
    assign BUSY = busy_q;
    assign ERASE_SUSPENDED = susp_q;
endmodule

// [fpq_host.sv]
// host bus controller model issuing command writes and table reads
`timescale 1ns/10ps
module fpq_host (
    input wire logic clk, // clock
    output logic ce_n = 1'b1, // chip select
    output logic we_n = 1'b1, // write strobe
    output logic oe_n = 1'b1, // output enable
    output logic [11:0] addr = 12'h000, // word address
    output logic [15:0] din = 16'h0000 // write data
);
    // one write cycle, released lines show the inverse value afterwards
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk);
        ce_n <= 1'b0;
        we_n <= 1'b0;
        addr <= a;
        din <= d;
        @(posedge clk);
        ce_n <= 1'b1;
        we_n <= 1'b1;
        addr <= ~a;
        din <= ~d;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        ce_n <= 1'b0;
        oe_n <= 1'b0;
        addr <= a;
        repeat (2) @(posedge clk);
        ce_n <= 1'b1;
        oe_n <= 1'b1;
        addr <= ~a;
    endtask
    // strobe with output enable low, must not count as a write
    task automatic wr_inh(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk);
        ce_n <= 1'b0;
        we_n <= 1'b0;
        oe_n <= 1'b0;
        addr <= a;
        din <= d;
        @(posedge clk);
        ce_n <= 1'b1;
        we_n <= 1'b1;
        oe_n <= 1'b1;
        addr <= ~a;
        din <= ~d;
    endtask
endmodule

// [fpq_ctrl_chk.sv]
// port checker of the flash protect and query controller
`timescale 1ns/10ps
module fpq_ctrl_chk (
    input wire logic CLK, // clock
    input wire logic RST, // reset
    input wire logic CE_N, // select
    input wire logic WE_N, // strobe
    input wire logic OE_N, // output enable
    input wire logic [11:0] ADDR, // address
    input wire logic [7:0] SECT, // sector
    input wire logic [15:0] DIN, // data
    input wire logic WP_N, // write protect
    input wire logic BOOST_SUPPLY_PIN, // boost pin
    input wire logic SUPPLY_LOCKOUT, // lockout
    input wire logic ALGO_DONE, // op done
    input wire logic [15:0] QUERY_DATA, // table word
    input wire logic QUERY_MODE, // query
    input wire logic REGION_MODE, // region
    input wire logic REGION_LOCKED, // region lock
    input wire logic PROG_START, // program pulse
    input wire logic BUSY, // busy
    input wire logic SECT_WRITABLE // writable
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    chk_start_busy: assert property (PROG_START |-> BUSY) else $error("program start without busy");
    chk_boost_lock: assert property (!BOOST_SUPPLY_PIN && !REGION_MODE |-> !SECT_WRITABLE)
        else $error("sector writable with boost pin low");
    chk_wp_boot: assert property (!WP_N && !REGION_MODE && (SECT <= 8'd3 || SECT >= 8'd138) |-> !SECT_WRITABLE)
        else $error("boot sector writable with write protect low");
    chk_lock_sticky: assert property (REGION_LOCKED |=> REGION_LOCKED) else $error("region lock cleared");
    chk_region_prog: assert property (REGION_MODE && $past(REGION_MODE) |-> !PROG_START)
        else $error("program started in region");
    chk_lockout_read: assert property (SUPPLY_LOCKOUT |=> !QUERY_MODE && !PROG_START)
        else $error("lockout left query or start");
    chk_query_upper: assert property (QUERY_MODE |-> QUERY_DATA[15:8] == 8'h00) else $error("upper byte set");
    chk_query_id: assert property (QUERY_MODE && $past(QUERY_MODE) && $past(ADDR[7:0]) == 8'h10 |-> QUERY_DATA == 16'h0051)
        else $error("query identifier wrong");
    chk_query_entry: assert property ($rose(QUERY_MODE) |-> $past(!CE_N && !WE_N && OE_N && DIN[7:0] == 8'h98))
        else $error("query entered without write");
    chk_done_idle: assert property (BUSY && ALGO_DONE |=> !BUSY) else $error("busy after done");
    cover property (PROG_START);
    cover property (REGION_LOCKED);
    cover property (QUERY_MODE && QUERY_DATA == 16'h0051);
endmodule

// [testbench.sv]
// self-checking testbench of the flash protect and query controller
`timescale 1ns/10ps
module testbench;
    logic clk = 1'b0, rst = 1'b1, wp_n = 1'b1, boost = 1'b1, lockout = 1'b0, pwr = 1'b0, done = 1'b0, tmo = 1'b0;
    logic [7:0] sect = 8'h10;
    logic [31:0] seed = 32'h37727a62;
    logic [31:0] r;
    wire logic ce_n, we_n, oe_n, qm, am, rm, rl, ps, es, bsy, esus, sw;
    wire logic [11:0] addr;
    wire logic [15:0] din, q;
    wire logic [7:0] os;
    int miscompares = 0, tests_run = 0;
    logic [7:0] qa [13] = '{8'h10, 8'h11, 8'h12, 8'h40, 8'h41, 8'h42, 8'h43, 8'h49, 8'h4f, 8'h58, 8'h59, 8'h5a, 8'h5b};
    logic [15:0] qd [13] = '{16'h0051, 16'h0052, 16'h0059, 16'h0050, 16'h0052, 16'h0049, 16'h0031, 16'h0007,
        16'h0001, 16'h0017, 16'h0030, 16'h0030, 16'h0017};
    logic [7:0] corner [6] = '{8'd3, 8'd4, 8'd137, 8'd138, 8'd141, 8'd142};
    always #12.5 clk = ~clk;
    fpq_host i_fpq_host (.clk(clk), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .din(din));
    fpq_ctrl i_fpq_ctrl (.CLK(clk), .RST(rst), .CE_N(ce_n), .WE_N(we_n), .OE_N(oe_n), .ADDR(addr), .SECT(sect),
        .REGION_ADDR(1'b0), .DIN(din), .WP_N(wp_n), .BOOST_SUPPLY_PIN(boost), .SUPPLY_LOCKOUT(lockout),
        .POWER_UP(pwr), .ALGO_DONE(done), .TIMEOUT_STATUS_BIT(tmo), .QUERY_DATA(q), .QUERY_MODE(qm),
        .AUTOSEL_MODE(am), .REGION_MODE(rm), .REGION_LOCKED(rl), .PROG_START(ps), .ERASE_START(es),
        .OP_SECT(os), .BUSY(bsy), .ERASE_SUSPENDED(esus), .SECT_WRITABLE(sw));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic can_write(input logic [7:0] s, input logic wp);
        return s < 8'd142 && !(!wp && (s <= 8'd3 || s >= 8'd138));
    endfunction
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        i_fpq_host.wr(12'h555, 16'h00aa);
        i_fpq_host.wr(12'h2aa, 16'h0055);
        i_fpq_host.wr(12'h555, {8'h00, c});
    endtask
    // watch for a start pulse, then finish the operation
    task automatic start_seen(input logic exp, input logic [7:0] s);
        logic seen;
        seen = 1'b0;
        repeat (4) begin
            #1 if ((ps | es) === 1'b1) seen = 1'b1;
            @(posedge clk);
        end
        check(seen, exp);
        if (seen) begin
            check(os, s);
            check(bsy, 1'b1);
            done <= 1'b1;
            @(posedge clk);
            done <= 1'b0;
            @(posedge clk);
            #1 check(bsy, 1'b0);
        end
    endtask
    task automatic prog(input logic [7:0] s, input logic full, input logic exp);
        logic [31:0] v;
        v = rnd();
        sect <= s;
        if (full) cmd(8'ha0);
        else i_fpq_host.wr(12'h555, 16'h00a0);
        i_fpq_host.wr(v[11:0], v[31:16]);
        start_seen(exp, s);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        foreach (corner[i]) for (int w = 0; w < 2; w++) begin
            wp_n <= w[0];
            prog(corner[i], 1'b1, can_write(corner[i], w[0]));
        end
        repeat (6) begin
            r = rnd();
            wp_n <= r[8];
            prog(r[7:0], 1'b1, can_write(r[7:0], r[8]));
        end
        wp_n <= 1'b1;
        prog(8'd50, 1'b0, 1'b0);
        boost <= 1'b0;
        prog(8'd50, 1'b1, 1'b0);
        boost <= 1'b1;
        sect <= 8'd60;
        cmd(8'he0);
        prog(8'd60, 1'b1, 1'b0);
        cmd(8'he1);
        prog(8'd60, 1'b1, 1'b1);
        cmd(8'h60);
        i_fpq_host.wr(12'h000, 16'h0060);
        start_seen(1'b0, 8'd60);
        cmd(8'ha0);
        i_fpq_host.wr(12'h000, 16'h1234);
        #1 check(bsy, 1'b1);
        i_fpq_host.wr(12'h000, 16'h00f0);
        i_fpq_host.wr(12'h000, 16'h00b0);
        #1 check({bsy, esus}, 2'b10);
        tmo <= 1'b1;
        i_fpq_host.wr(12'h000, 16'h00f0);
        #1 check(bsy, 1'b0);
        tmo <= 1'b0;
        i_fpq_host.wr(12'h055, 16'h0098);
        #1 check(qm, 1'b1);
        foreach (qa[i]) begin
            i_fpq_host.rd({4'h0, qa[i]});
            #1 check(q, qd[i]);
        end
        r = rnd();
        i_fpq_host.wr(r[11:0], 16'h00f0);
        #1 check(qm, 1'b0);
        cmd(8'h90);
        #1 check(am, 1'b1);
        i_fpq_host.wr(12'h055, 16'h0098);
        #1 check({qm, am}, 2'b10);
        i_fpq_host.wr(12'hfff, 16'h00f0);
        #1 check({qm, am}, 2'b01);
        i_fpq_host.wr(12'h000, 16'h00f0);
        #1 check(am, 1'b0);
        i_fpq_host.wr(12'h055, 16'h0098);
        lockout <= 1'b1;
        repeat (2) @(posedge clk);
        #1 check(qm, 1'b0);
        i_fpq_host.wr(12'h055, 16'h0098);
        #1 check(qm, 1'b0);
        lockout <= 1'b0;
        pwr <= 1'b1;
        i_fpq_host.wr(12'h055, 16'h0098);
        #1 check(qm, 1'b0);
        pwr <= 1'b0;
        i_fpq_host.wr_inh(12'h055, 16'h0098);
        #1 check(qm, 1'b0);
        sect <= 8'd70;
        cmd(8'h80);
        i_fpq_host.wr(12'h555, 16'h00aa);
        i_fpq_host.wr(12'h2aa, 16'h0055);
        i_fpq_host.wr(12'h000, 16'h0030);
        #1 check(bsy, 1'b1);
        i_fpq_host.wr(12'h000, 16'h00b0);
        #1 check(esus, 1'b1);
        i_fpq_host.wr(12'h000, 16'h0030);
        #1 check(esus, 1'b0);
        start_seen(1'b0, 8'd70);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        cmd(8'h88);
        #1 check(rm, 1'b1);
        cmd(8'h60);
        i_fpq_host.wr(12'h555, 16'h0060);
        #1 check({rl, sw}, 2'b10);
        prog(8'd0, 1'b1, 1'b0);
        cmd(8'h80);
        cmd(8'h00);
        #1 check({rm, rl}, 2'b01);
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end
endmodule
bind fpq_ctrl fpq_ctrl_chk i_fpq_ctrl_chk (.CLK(CLK), .RST(RST), .CE_N(CE_N), .WE_N(WE_N), .OE_N(OE_N), .ADDR(ADDR),
    .SECT(SECT), .DIN(DIN), .WP_N(WP_N), .BOOST_SUPPLY_PIN(BOOST_SUPPLY_PIN), .SUPPLY_LOCKOUT(SUPPLY_LOCKOUT),
    .ALGO_DONE(ALGO_DONE), .QUERY_DATA(QUERY_DATA), .QUERY_MODE(QUERY_MODE), .REGION_MODE(REGION_MODE),
    .REGION_LOCKED(REGION_LOCKED), .PROG_START(PROG_START), .BUSY(BUSY), .SECT_WRITABLE(SECT_WRITABLE));
